// ==== rtl/bit_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // ----------------------------------------------------------------
  // two flip-flops, the first read only by the second
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule // bit_sync

`default_nettype wire

// ==== rtl/hsync_timing.sv ====
// Notes on behaviour
// - clock out rises midway between data changes
// - four invalid sets precede first valid
// - sampling phase set in 32 steps
// - input sync polarity detected, output polarity known
// - one control bit selects output polarity
// - bit zero active high, one active low
// - sync out aligned with clock and data
// - sync active width from width register
// - width eight bits, resets to 0x20
// - phase five bits, resets to 0x10
// - coast blocks sync to clock recovery
// - coast synchronised before gating sync path
`timescale 1ns/1ps
`default_nettype none

module hsync_timing #(
  parameter logic [7:0] CHIP_REV = 8'h00 // arbitrary value
) (
  input  wire logic                                    clk,
  input  wire logic                                    rst_n,
  input  wire logic [hsync_timing_pkg::ADDR_W-1:0]     avs_address,
  input  wire logic                                    avs_read,
  input  wire logic                                    avs_write,
  input  wire logic [31:0]                             avs_writedata,
  input  wire logic [3:0]                              avs_byteenable,
  output logic      [31:0]                             avs_readdata,
  output logic                                         avs_waitrequest,
  output logic      [11:0]                             pll_divider,
  output logic      [1:0]                              vco_range_select,
  output logic      [2:0]                              charge_pump_current,
  output logic      [4:0]                              sample_phase,
  input  wire logic                                    pix_clk,
  input  wire logic                                    hsync_in,
  input  wire logic                                    coast_in,
  input  wire logic [hsync_timing_pkg::PIX_W-1:0]      pixel_data_in,
  output logic      [hsync_timing_pkg::PIX_W-1:0]      pixel_data_out,
  output logic                                         data_valid,
  output logic                                         sync_out,
  output logic                                         pixel_data_clock_out,
  output logic                                         pll_sync_ref,
  output logic                                         pll_coast
);
  import hsync_timing_pkg::*;

  // ----------------------------------------------------------------
  // local field layout and counter steps
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W     = 3;
  localparam int unsigned STATUS_W   = 3;
  localparam int unsigned BYTE_W     = 8;
  localparam logic [7:0]  CNT_FIRST  = 8'h01;
  localparam logic [7:0]  CNT_STEP   = 8'h01;
  localparam logic [7:0]  WIDTH_NONE = 8'h00;

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        div_upper;
    logic [3:0]        div_lower;
    logic [1:0]        vco;
    logic [2:0]        pump;
    logic [4:0]        phase;
    logic [7:0]        width;
    logic [2:0]        ctrl;
    logic              ack;
    logic [31:0]       rdata;
    xfer_state_t       xf;
    logic              dirty;
    logic              req_tog;
    logic [XFER_W-1:0] xfer;
  } bus_state_t;

  typedef struct packed {
    logic [PIPE_DEPTH-1:0][PIX_W-1:0] pipe;
    logic [PIPE_DEPTH-1:0]            edge_pipe;
    logic [PIX_W-1:0]                 data_out;
    logic [2:0]                       fill;
    logic                             valid;
    logic                             hs_prev;
    logic                             norm_prev;
    logic [RUN_W-1:0]                 run;
    logic [RUN_W-1:0]                 high_run;
    logic [RUN_W-1:0]                 low_run;
    logic                             det_high;
    logic                             sync_act;
    logic [7:0]                       cnt;
    logic                             sync_o;
    logic                             ref_o;
    logic [7:0]                       width;
    logic [2:0]                       ctrl;
    logic                             req_seen;
    logic                             ack_tog;
  } pix_state_t;

  localparam bus_state_t BUS_RESET = '{
    div_upper: RST_DIV_UPPER, div_lower: RST_DIV_LOWER, vco: RST_VCO_RANGE,
    pump: RST_PUMP, phase: RST_PHASE, width: RST_SYNC_WIDTH, ctrl: RST_SYNC_CTRL,
    ack: 1'b0, rdata: 32'h0000_0000, xf: XF_IDLE, dirty: 1'b0, req_tog: 1'b0,
    xfer: {RST_SYNC_WIDTH, RST_SYNC_CTRL}};

  localparam pix_state_t PIX_RESET = '{
    pipe: '0, edge_pipe: '0, data_out: '0, fill: 3'h0, valid: 1'b0,
    hs_prev: 1'b0, norm_prev: 1'b0, run: '0, high_run: '0, low_run: '0,
    det_high: 1'b0, sync_act: 1'b0, cnt: 8'h00, sync_o: 1'b0, ref_o: 1'b0,
    width: RST_SYNC_WIDTH, ctrl: RST_SYNC_CTRL, req_seen: 1'b0, ack_tog: 1'b0};

  bus_state_t b_q;
  bus_state_t b_d;
  pix_state_t p_q;
  pix_state_t p_d;

  // byte-lane 0 merge for writable registers
  function automatic logic [7:0] lane0(input logic [7:0]  old,
                                       input logic [31:0] wd,
                                       input logic [3:0]  be);
    lane0 = be[0] ? wd[7:0] : old;
  endfunction

  // register byte in the low lane, upper lanes zero
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  logic       ack_s;
  logic [2:0] status_s;
  logic       hs_s;
  logic       coast_s;
  logic       req_s;

  // handshake acknowledge back into the bus domain
  bit_sync #(.W(1)) u_ack_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (p_q.ack_tog),
    .sync_out (ack_s)
  );

  // status bits are independent levels, each synchronised alone
  bit_sync #(.W(3)) u_status_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({p_q.valid, coast_s, p_q.det_high}),
    .sync_out (status_s)
  );

  // coast is asynchronous to the pixel clock
  bit_sync #(.W(3)) u_pix_sync (
    .clk      (pix_clk),
    .rst_n    (rst_n),
    .async_in ({b_q.req_tog, coast_in, hsync_in}),
    .sync_out ({req_s, coast_s, hs_s})
  );

  // ----------------------------------------------------------------
  // register bus side
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_wr;

  assign bus_req = avs_read | avs_write;
  assign bus_wr  = avs_write & b_q.ack;

  always_comb begin
    b_d     = b_q;
    b_d.ack = bus_req & ~b_q.ack;
    if (bus_req && !b_q.ack) begin
      case (avs_address)
        IDX_REVISION:   b_d.rdata = byte_word(CHIP_REV);
        IDX_DIV_UPPER:  b_d.rdata = byte_word(b_q.div_upper);
        IDX_DIV_LOWER:  b_d.rdata = byte_word({b_q.div_lower, 4'h0});
        IDX_CLK_GEN:    b_d.rdata = byte_word({b_q.vco, b_q.pump, 3'h0});
        IDX_PHASE:      b_d.rdata = byte_word({b_q.phase, 3'h0});
        IDX_SYNC_WIDTH: b_d.rdata = byte_word(b_q.width);
        IDX_SYNC_CTRL:  b_d.rdata = byte_word({b_q.ctrl, 5'h00});
        IDX_STATUS:     b_d.rdata = byte_word({{(BYTE_W-STATUS_W){1'b0}}, status_s});
        default:        b_d.rdata = byte_word(8'h00);
      endcase
    end
    // configuration handshake toward the pixel domain
    case (b_q.xf)
      XF_IDLE: begin
        if (b_q.dirty) begin
          b_d.xfer    = {b_q.width, b_q.ctrl};
          b_d.req_tog = ~b_q.req_tog;
          b_d.dirty   = 1'b0;
          b_d.xf      = XF_WAIT;
        end
      end
      XF_WAIT: begin
        // next word only after the pixel side has acknowledged
        if (ack_s == b_q.req_tog) begin
          b_d.xf = XF_IDLE;
        end
      end
      default: b_d.xf = XF_IDLE;
    endcase
    // writes land at the edge where waitrequest is low
    if (bus_wr) begin
      case (avs_address)
        IDX_DIV_UPPER: b_d.div_upper = lane0(b_q.div_upper, avs_writedata, avs_byteenable);
        IDX_DIV_LOWER: begin
          if (avs_byteenable[0]) begin
            b_d.div_lower = avs_writedata[DIV_LOWER_LSB +: 4];
          end
        end
        IDX_CLK_GEN: begin
          if (avs_byteenable[0]) begin
            b_d.vco  = avs_writedata[VCO_LSB +: 2];
            b_d.pump = avs_writedata[PUMP_LSB +: 3];
          end
        end
        IDX_PHASE: begin
          if (avs_byteenable[0]) begin
            b_d.phase = avs_writedata[PHASE_LSB +: 5];
          end
        end
        IDX_SYNC_WIDTH: begin
          b_d.width = lane0(b_q.width, avs_writedata, avs_byteenable);
          b_d.dirty = b_d.dirty | avs_byteenable[0];
        end
        IDX_SYNC_CTRL: begin
          if (avs_byteenable[0]) begin
            b_d.ctrl  = avs_writedata[CTRL_LSB +: 3];
            b_d.dirty = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_q <= BUS_RESET;
    end else begin
      b_q <= b_d;
    end
  end

  // exactly one wait state: the answer is registered
  assign avs_waitrequest     = bus_req & ~b_q.ack;
  assign avs_readdata        = b_q.rdata;
  assign pll_divider         = {b_q.div_upper, b_q.div_lower};
  assign vco_range_select    = b_q.vco;
  assign charge_pump_current = b_q.pump;
  assign sample_phase        = b_q.phase;

  // ----------------------------------------------------------------
  // pixel clock side
  // ----------------------------------------------------------------
  logic act_high;
  logic norm;
  logic lead;
  logic pol_known;

  always_comb begin
    p_d = p_q;
    // polarity: the shorter of the two run lengths is the active level
    if (hs_s == p_q.hs_prev) begin
      if (p_q.run != {RUN_W{1'b1}}) begin
        p_d.run = p_q.run + 1'b1;
      end
    end else begin
      p_d.run = {{(RUN_W-1){1'b0}}, 1'b1};
      if (p_q.hs_prev) begin
        p_d.high_run = p_q.run;
      end else begin
        p_d.low_run = p_q.run;
      end
    end
    p_d.hs_prev  = hs_s;
    p_d.det_high = p_q.high_run < p_q.low_run;
    act_high     = p_q.ctrl[CTRL_OVERRIDE] ? p_q.ctrl[CTRL_IN_POL] : p_q.det_high;
    norm         = act_high ? hs_s : ~hs_s;
    // no leading edge until both run lengths have been measured
    pol_known    = (p_q.high_run != '0) && (p_q.low_run != '0);
    lead         = norm & ~p_q.norm_prev & pol_known;
    p_d.norm_prev = norm;
    // reference to clock recovery is held off while coasting
    p_d.ref_o = norm & ~coast_s;
    // data and sync edge travel the same pipeline
    p_d.pipe      = {p_q.pipe[PIPE_DEPTH-2:0], pixel_data_in};
    p_d.edge_pipe = {p_q.edge_pipe[PIPE_DEPTH-2:0], lead};
    p_d.data_out  = p_q.pipe[PIPE_DEPTH-1];
    if (p_q.fill != 3'(PIPE_DEPTH)) begin
      p_d.fill = p_q.fill + 3'h1;
    end
    p_d.valid = (p_q.fill == 3'(PIPE_DEPTH));
    // width counter from the aligned leading edge
    // zero width gives no pulse
    if (p_q.edge_pipe[PIPE_DEPTH-1] && (p_q.width != WIDTH_NONE)) begin
      p_d.sync_act = 1'b1;
      p_d.cnt      = CNT_FIRST;
    end else if (p_q.sync_act) begin
      if (p_q.cnt >= p_q.width) begin
        p_d.sync_act = 1'b0;
        p_d.cnt      = 8'h00;
      end else begin
        p_d.cnt = p_q.cnt + CNT_STEP;
      end
    end
    // output polarity: 0 active high, 1 active low
    p_d.sync_o = p_d.sync_act ^ p_q.ctrl[CTRL_OUT_POL];
    // configuration arrives held stable by the handshake
    if (req_s != p_q.req_seen) begin
      p_d.req_seen = req_s;
      p_d.width    = b_q.xfer[XFER_W-1:CTRL_W];
      p_d.ctrl     = b_q.xfer[CTRL_W-1:0];
      p_d.ack_tog  = ~p_q.ack_tog;
    end
  end

  always_ff @(posedge pix_clk or negedge rst_n) begin
    if (!rst_n) begin
      p_q <= PIX_RESET;
    end else begin
      p_q <= p_d;
    end
  end

  // ----------------------------------------------------------------
  // pixel side outputs, all from flip-flops but the data clock
  // ----------------------------------------------------------------
  assign pixel_data_out       = p_q.data_out;
  assign data_valid           = p_q.valid;
  assign sync_out             = p_q.sync_o;
  assign pll_sync_ref         = p_q.ref_o;
  assign pll_coast            = coast_s;
  // data changes on the rising pixel edge, so this rises midway between
  assign pixel_data_clock_out = ~pix_clk;

endmodule // hsync_timing

`default_nettype wire

// ==== rtl/hsync_timing_pkg.sv ====
`default_nettype none

package hsync_timing_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 5;
  localparam logic [4:0]  IDX_REVISION    = 5'h00;
  localparam logic [4:0]  IDX_DIV_UPPER   = 5'h01;
  localparam logic [4:0]  IDX_DIV_LOWER   = 5'h02;
  localparam logic [4:0]  IDX_CLK_GEN     = 5'h03;
  localparam logic [4:0]  IDX_PHASE       = 5'h04;
  localparam logic [4:0]  IDX_SYNC_WIDTH  = 5'h07;
  localparam logic [4:0]  IDX_SYNC_CTRL   = 5'h0e;
  localparam logic [4:0]  IDX_STATUS      = 5'h10;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_DIV_UPPER   = 8'h69;
  localparam logic [3:0]  RST_DIV_LOWER   = 4'hd;
  localparam logic [1:0]  RST_VCO_RANGE   = 2'h1;
  localparam logic [2:0]  RST_PUMP        = 3'h1;
  localparam logic [4:0]  RST_PHASE       = 5'h10;
  localparam logic [7:0]  RST_SYNC_WIDTH  = 8'h20;
  localparam logic [2:0]  RST_SYNC_CTRL   = 3'h2;
  localparam int unsigned DIV_LOWER_LSB   = 4;
  localparam int unsigned VCO_LSB         = 6;
  localparam int unsigned PUMP_LSB        = 3;
  localparam int unsigned PHASE_LSB       = 3;
  localparam int unsigned CTRL_LSB        = 5;
  // sync control field: [2] override, [1] forced input polarity, [0] output polarity
  localparam int unsigned CTRL_OVERRIDE   = 2;
  localparam int unsigned CTRL_IN_POL     = 1;
  localparam int unsigned CTRL_OUT_POL    = 0;
  localparam int unsigned ST_POL_BIT      = 0;
  localparam int unsigned ST_COAST_BIT    = 1;
  localparam int unsigned ST_VALID_BIT    = 2;

  // ----------------------------------------------------------------
  // widths and pipeline
  // ----------------------------------------------------------------
  localparam int unsigned PIX_W           = 8;
  localparam int unsigned PIPE_DEPTH      = 4;
  localparam int unsigned RUN_W           = 16;
  localparam int unsigned XFER_W          = 11;

  typedef enum logic [0:0] {
    XF_IDLE = 1'b0,
    XF_WAIT = 1'b1
  } xfer_state_t;

endpackage

`default_nettype wire

// ==== tb/display_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module display_sink (
  input  wire logic       rst_n,
  input  wire logic       pixel_data_clock_out,
  input  wire logic [7:0] pixel_data_out,
  input  wire logic       data_valid,
  input  wire logic       sync_out,
  input  wire logic       active_low,
  output logic      [7:0] run_len,
  output logic      [7:0] lead_data,
  output int              leads,
  output int              discards
);
  logic       act;
  logic       act_q;
  logic       upd_q;
  logic [7:0] cnt_q;
  assign act = sync_out ^ active_low;
  initial begin
    leads = 0;
    discards = 0;
    act_q = 1'b0;
    cnt_q = 8'h00;
    run_len = 8'h00;
  end
  // an update edge has passed since reset
  always @(negedge pixel_data_clock_out) upd_q <= rst_n;
  // latch mid data eye, on the output clock rise
  always @(posedge pixel_data_clock_out) begin
    if (!data_valid) begin
      if (upd_q) discards <= discards + 1;
    end else begin
      act_q <= act;
      if (act && !act_q) begin
        leads <= leads + 1;
        lead_data <= pixel_data_out;
        cnt_q <= 8'd1;
      end else if (act) cnt_q <= cnt_q + 8'd1;
      else if (act_q) run_len <= cnt_q;
    end
  end
endmodule // display_sink
`default_nettype wire

// ==== tb/hsync_timing_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module hsync_timing_checker (
  input wire logic                                clk,
  input wire logic                                rst_n,
  input wire logic [hsync_timing_pkg::ADDR_W-1:0] avs_address,
  input wire logic                                avs_read,
  input wire logic                                avs_write,
  input wire logic [31:0]                         avs_writedata,
  input wire logic [3:0]                          avs_byteenable,
  input wire logic                                avs_waitrequest,
  input wire logic [4:0]                          sample_phase,
  input wire logic                                pix_clk,
  input wire logic                                coast_in,
  input wire logic                                data_valid,
  input wire logic                                pixel_data_clock_out,
  input wire logic                                pll_sync_ref,
  input wire logic                                pll_coast
);
  import hsync_timing_pkg::*;
  logic [3:0] upd_q;
  logic [3:0] upd_d;
  logic [4:0] wd_phase;
  logic       ph_wr;
  assign wd_phase = avs_writedata[7:3];
  assign ph_wr = avs_write && !avs_waitrequest && avs_address == IDX_PHASE && avs_byteenable[0];
  // pixel updates since reset, saturating
  assign upd_d = (upd_q == 4'hf) ? upd_q : upd_q + 4'h1;
  always_ff @(posedge pix_clk or negedge rst_n) begin
    if (!rst_n) upd_q <= 4'h0;
    else upd_q <= upd_d;
  end

  clk_out_inv_a: assert property (@(posedge clk) disable iff (!rst_n)
    pixel_data_clock_out != pix_clk) else $error("data clock not inverse of pixel clock");
  valid_hold_a: assert property (@(posedge pix_clk) disable iff (!rst_n)
    data_valid |=> data_valid) else $error("data valid dropped");
  valid_late_a: assert property (@(posedge pix_clk) disable iff (!rst_n)
    data_valid |-> upd_q >= 4'd5) else $error("data valid too early");
  coast_sync_a: assert property (@(posedge pix_clk) disable iff (!rst_n)
    upd_q >= 4'h2 |-> pll_coast == $past(coast_in, 2)) else $error("coast not two-stage synchronised");
  coast_gate_a: assert property (@(posedge pix_clk) disable iff (!rst_n)
    pll_coast && $past(pll_coast) |-> !pll_sync_ref) else $error("sync reference while coasting");
  wait_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait in first cycle");
  wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
  phase_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    ph_wr |=> sample_phase == $past(wd_phase)) else $error("phase write not applied");
  phase_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ph_wr |=> $stable(sample_phase)) else $error("phase changed without write");
endmodule // hsync_timing_checker

bind hsync_timing hsync_timing_checker u_hsync_timing_checker (
  .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .sample_phase, .pix_clk, .coast_in, .data_valid, .pixel_data_clock_out,
  .pll_sync_ref, .pll_coast
);
`default_nettype wire

// ==== tb/hsync_timing_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module hsync_timing_tb_top;
  import hsync_timing_pkg::*;
  typedef struct packed {logic [4:0] idx; logic [7:0] rst; logic [7:0] wv; logic [7:0] rb;} row_t;
  logic        clk = 1'b0, pix_clk = 1'b0, rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [11:0] pll_divider;
  logic [1:0]  vco_range_select;
  logic [2:0]  charge_pump_current;
  logic [4:0]  sample_phase;
  logic        hsync_in = 1'b1, hs_low = 1'b1, act_low = 1'b1;
  logic        coast_in = 1'b0;
  logic [7:0]  pixel_data_in = 8'h00, pixel_data_out, pos = 8'h00;
  logic [7:0]  rd, run_len, lead_data, l0;
  logic        avs_waitrequest, data_valid, sync_out, pixel_data_clock_out, pll_sync_ref, pll_coast;
  int          leads, discards, hi, n;
  int          miscompares = 0, total_checks = 0;
  row_t        rows [8] = '{
    '{IDX_DIV_UPPER, 8'h69, 8'h31, 8'h31}, '{IDX_DIV_LOWER, 8'hd0, 8'hf5, 8'hf0},
    '{IDX_CLK_GEN, 8'h48, 8'h08, 8'h08}, '{IDX_PHASE, 8'h80, 8'hf8, 8'hf8},
    '{IDX_SYNC_WIDTH, 8'h20, 8'h03, 8'h03}, '{IDX_SYNC_CTRL, 8'h40, 8'h20, 8'h20},
    '{IDX_REVISION, 8'h00, 8'hff, 8'h00}, '{5'h1f, 8'h00, 8'haa, 8'h00}};

  hsync_timing u_hsync_timing (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .pll_divider, .vco_range_select, .charge_pump_current,
    .sample_phase, .pix_clk, .hsync_in, .coast_in, .pixel_data_in, .pixel_data_out,
    .data_valid, .sync_out, .pixel_data_clock_out, .pll_sync_ref, .pll_coast);
  display_sink u_display_sink (
    .rst_n, .pixel_data_clock_out, .pixel_data_out, .data_valid, .sync_out,
    .active_low(act_low), .run_len, .lead_data, .leads, .discards);

  initial forever #5 clk = ~clk;
  initial begin
    #7;
    forever #15 pix_clk = ~pix_clk;
  end
  // 40-pixel lines, 6-pixel input sync
  always @(posedge pix_clk) begin
    pos <= (pos == 8'd39) ? 8'd0 : pos + 8'd1;
    hsync_in <= (pos < 8'd6) ^ hs_low;
    pixel_data_in <= pixel_data_in + 8'd1;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
    logic w;
    int k;
    w = 1'b1;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    // waitrequest and read data as they stood at this rising edge
    while (w !== 1'b0 && k < 20) begin
      @(posedge clk);
      w = avs_waitrequest;
      rd = avs_readdata[7:0];
      k++;
    end
    if (w !== 1'b0) miscompares++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic lines(input int c);
    repeat (c * 40) @(posedge pix_clk);
  endtask
  task automatic ref_count;
    hi = 0;
    repeat (80) begin
      @(negedge pix_clk);
      hi += int'(pll_sync_ref);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].idx, 8'h00);
      check("reset value", {4'h0, rd}, {4'h0, rows[i].rst});
      bus(1'b1, rows[i].idx, rows[i].wv);
      bus(1'b0, rows[i].idx, 8'h00);
      check("readback", {4'h0, rd}, {4'h0, rows[i].rb});
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, IDX_PHASE, 8'h00);
    avs_byteenable <= 4'h1;
    bus(1'b0, IDX_PHASE, 8'h00);
    check("masked write", {4'h0, rd}, 12'h0f8);
    check("divider", pll_divider, 12'h31f);
    check("phase out", {7'h0, sample_phase}, 12'h01f);
    lines(6);
    check("discarded", discards[11:0], 12'd4);
    check("width low", {4'h0, run_len}, 12'd3);
    l0 = lead_data;
    lines(1);
    check("line step", {4'h0, 8'(lead_data - l0)}, 12'd40);
    bus(1'b0, IDX_STATUS, 8'h00);
    check("status low", {4'h0, rd}, 12'h004);
    bus(1'b1, IDX_SYNC_CTRL, 8'h00);
    act_low <= 1'b0;
    hs_low <= 1'b0;
    lines(6);
    check("width high", {4'h0, run_len}, 12'd3);
    bus(1'b0, IDX_STATUS, 8'h00);
    check("status high", {4'h0, rd}, 12'h005);
    ref_count();
    check("ref runs", {11'h0, hi != 0}, 12'h001);
    @(posedge pix_clk);
    coast_in <= 1'b1;
    n = leads;
    repeat (4) @(posedge pix_clk);
    ref_count();
    check("ref coasted", {11'h0, hi != 0}, 12'h000);
    check("sync kept", {11'h0, leads > n}, 12'h001);
    @(posedge pix_clk);
    coast_in <= 1'b0;
    bus(1'b1, IDX_SYNC_WIDTH, 8'h00);
    lines(2);
    n = leads;
    lines(3);
    check("no pulse", leads[11:0], n[11:0]);
    report_and_stop();
  end
endmodule // hsync_timing_tb_top
`default_nettype wire
